// file: core/wake_cfg_pkg.sv
// constants shared by the wake source configuration block
package wake_cfg_pkg;

  // register indices; the byte address is four times the index
  localparam logic [5:0] IDX_INTERNAL = 6'h06;
  localparam logic [5:0] IDX_EXTERNAL = 6'h07;
  localparam logic [5:0] IDX_TERMINATION = 6'h08;
  localparam logic [5:0] IDX_FILTER = 6'h09;

  // internal_wake_config fields
  localparam int BIT_TIMER_B_WAKE = 7;
  localparam int BIT_TIMER_A_WAKE = 6;
  localparam int BIT_STOP_OFF_HI = 2;

  // external_wake_config fields
  localparam int BIT_INT_GLOBAL = 7;
  localparam int BIT_MEASURE = 5;
  localparam int BIT_WAKE_C = 2;
  localparam int BIT_WAKE_B = 1;
  localparam int BIT_WAKE_A = 0;

  // two-bit field per wake input, input n at bits 2n+1:2n
  localparam int FIELD_W = 2;
  localparam int WAKE_INPUTS = 3;

  // reset values
  localparam logic [7:0] RST_INTERNAL = 8'h00;
  localparam logic [7:0] RST_EXTERNAL = 8'h07;
  localparam logic [7:0] RST_TERMINATION = 8'h00;
  localparam logic [7:0] RST_FILTER = 8'h00;

  // bits that hold software values; all others read zero
  localparam logic [7:0] RW_INTERNAL = 8'hC4;
  localparam logic [7:0] RW_EXTERNAL = 8'hA7;
  localparam logic [7:0] RW_TERMINATION = 8'h3F;
  localparam logic [7:0] RW_FILTER = 8'h3F;

  // bits that survive a restart
  localparam logic [7:0] KEEP_INTERNAL = 8'hC0;
  localparam logic [7:0] KEEP_EXTERNAL = 8'hA7;
  localparam logic [7:0] KEEP_TERMINATION = 8'h3F;
  localparam logic [7:0] KEEP_FILTER = 8'h3F;

  // fail-safe pattern on external_wake_config: bits 2:0 set, 6, 4 and 3 cleared
  localparam logic [7:0] FAILSAFE_SET = 8'h07;
  localparam logic [7:0] FAILSAFE_CLEAR = 8'h58;

  // termination codes
  localparam logic [1:0] TERM_NONE = 2'h0;
  localparam logic [1:0] TERM_PULL_DOWN = 2'h1;
  localparam logic [1:0] TERM_PULL_UP = 2'h2;
  localparam logic [1:0] TERM_AUTO = 2'h3;

  // filter codes
  localparam logic [1:0] FLT_STATIC_SHORT = 2'h0;
  localparam logic [1:0] FLT_STATIC_LONG = 2'h1;
  localparam logic [1:0] FLT_CYCLIC_A = 2'h2;
  localparam logic [1:0] FLT_CYCLIC_B = 2'h3;

  // timing
  localparam int CLK_MHZ = 40;
  localparam int FILTER_SHORT_US = 16;
  localparam int FILTER_LONG_US = 64;
  localparam int FILTER_SHORT_CYC = FILTER_SHORT_US * CLK_MHZ;
  localparam int FILTER_LONG_CYC = FILTER_LONG_US * CLK_MHZ;
  localparam int FILTER_CNT_W = $clog2(FILTER_LONG_CYC + 1);

endpackage

// file: core/wake_input_filter.sv
// level-change filter for one high-voltage wake input
`timescale 1ns/1ps
module wake_input_filter
  import wake_cfg_pkg::*;
#(
  parameter int SHORT_CYC = FILTER_SHORT_CYC,
  parameter int LONG_CYC = FILTER_LONG_CYC,
  parameter int CNT_W = FILTER_CNT_W
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clear,
  input wire logic pin_level,
  input wire logic [1:0] filter_code,
  input wire logic on_end_a,
  input wire logic on_end_b,
  output logic wake_pulse,
  output logic level
);

  generate
    if (SHORT_CYC < 1 || LONG_CYC < SHORT_CYC || LONG_CYC >= (1 << CNT_W))
    begin : bad_cfg
      $error("wake_input_filter: filter counts do not fit");
    end
  endgenerate

  localparam logic [CNT_W-1:0] SHORT_LAST = CNT_W'(SHORT_CYC - 1);
  localparam logic [CNT_W-1:0] LONG_LAST = CNT_W'(LONG_CYC - 1);

  logic [CNT_W-1:0] count;
  logic changed;
  logic [CNT_W-1:0] limit;
  logic cyclic;
  logic sample_now;
  logic qualified;

  assign changed = pin_level != level;
  assign cyclic = filter_code[1];
  // 64 us only for static code 01, every other code filters 16 us
  assign limit = (filter_code == FLT_STATIC_LONG) ? LONG_LAST : SHORT_LAST;
  // cyclic sensing only looks at the pin when the chosen timer on-time ends
  assign sample_now = (filter_code == FLT_CYCLIC_A) ? on_end_a : on_end_b;
  assign qualified = changed && (count >= limit) && (!cyclic || sample_now);

  // counts cycles of a stable difference; saturates so a late cyclic sample still sees it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      count <= '0;
    else if (clear || !changed || qualified)
      count <= '0;
    else if (count < limit)
      count <= count + CNT_W'(1);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      level <= 1'b0;
      wake_pulse <= 1'b0;
    end
    else
    begin
      wake_pulse <= qualified && !clear;
      if (qualified && !clear)
        level <= pin_level;
    end
  end

endmodule

// file: core/wake_source_control_regs.sv
// wake source configuration registers with apb access and wake qualification
// Functional notes
// - bit 7 enables timer b as wake
// - bit 6 enables timer a as wake
// - reserved bits ignore writes, read zero
// - bit 2 deactivates watchdog in stop; hardware-updatable
// - internal: reset zero, restart clears 5:0
// - external: reset 07, restart clears 6,4,3
// - bit 7 widens interrupt to all status
// - measure bit ignores wake inputs a, b
// - bits 2:0 enable wake inputs c,b,a
// - fail-safe forces bus and external patterns
// - two-bit termination code per wake input
// - termination/filter: reset zero, restart clears 7:6
// - static filter codes: 16 or 64 us
// - cyclic codes sample at timer on-time end
// - measurement runs only in normal mode
`timescale 1ns/1ps
module wake_source_control_regs
  import wake_cfg_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic soft_reset,
  input wire logic restart,
  input wire logic failsafe_entry,
  input wire logic stop_off_hw_set,
  input wire logic stop_off_hw_clear,
  input wire logic normal_mode,
  input wire logic status_event,
  input wire logic timer_a_wake_tick,
  input wire logic timer_b_wake_tick,
  input wire logic timer_a_on_end,
  input wire logic timer_b_on_end,
  input wire logic wake_pin_a,
  input wire logic wake_pin_b,
  input wire logic wake_pin_c,
  output logic cyclic_timer_a_wake_enable,
  output logic cyclic_timer_b_wake_enable,
  output logic watchdog_stop_off_hi,
  output logic measure_active,
  output logic [2:0] pull_up_enable,
  output logic [2:0] pull_down_enable,
  output logic wake_event,
  output logic [4:0] wake_source,
  output logic interrupt_request,
  output logic bus_wake_force
);

  generate
    if (ADDR_W < 6 || ADDR_W > 32)
    begin : bad_addr
      $error("wake_source_control_regs: ADDR_W must be 6 to 32");
    end
  endgenerate

  logic [7:0] internal_wake_config;
  logic [7:0] external_wake_config;
  logic [7:0] wake_input_termination;
  logic [7:0] wake_input_filter;

  logic [2:0] pin_meta;
  logic [2:0] pin_sync;
  logic [2:0] pin_filtered_wake;
  logic [2:0] pin_level;

  logic access_cycle;
  logic commit;
  logic write_commit;
  logic hit;
  logic [1:0] reg_sel;
  logic [7:0] read_value;
  logic [7:0] write_byte;

  logic wake_in_a_enable;
  logic wake_in_b_enable;
  logic wake_in_c_enable;
  logic measure_select;
  logic global_interrupt;
  logic [2:0] input_armed;
  logic [4:0] next_wake_source;

  // apb handshake: one wait state, then the commit edge
  assign access_cycle = psel && penable && !pready;
  assign commit = psel && penable && pready;
  assign write_commit = commit && pwrite && hit && pstrb[0];
  assign write_byte = pwdata[7:0];

  // address decode; low two bits must be zero for an aligned word
  always_comb
  begin
    hit = 1'b0;
    reg_sel = 2'h0;
    if (paddr[1:0] != 2'h0)
    begin
      hit = 1'b0;
    end
    else if (paddr[ADDR_W-1:2] == (ADDR_W-2)'(IDX_INTERNAL))
    begin
      hit = 1'b1;
      reg_sel = 2'h0;
    end
    else if (paddr[ADDR_W-1:2] == (ADDR_W-2)'(IDX_EXTERNAL))
    begin
      hit = 1'b1;
      reg_sel = 2'h1;
    end
    else if (paddr[ADDR_W-1:2] == (ADDR_W-2)'(IDX_TERMINATION))
    begin
      hit = 1'b1;
      reg_sel = 2'h2;
    end
    else if (paddr[ADDR_W-1:2] == (ADDR_W-2)'(IDX_FILTER))
    begin
      hit = 1'b1;
      reg_sel = 2'h3;
    end
  end

  // reserved positions are masked so they can never read back nonzero
  always_comb
  begin
    read_value = 8'h00;
    case (reg_sel)
      2'h0: read_value = internal_wake_config & RW_INTERNAL;
      2'h1: read_value = external_wake_config & RW_EXTERNAL;
      2'h2: read_value = wake_input_termination & RW_TERMINATION;
      default: read_value = wake_input_filter & RW_FILTER;
    endcase
    if (!hit)
      read_value = 8'h00;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= access_cycle;
      if (access_cycle)
      begin
        pslverr <= !hit;
        prdata <= {24'h00_0000, read_value};
      end
      else if (commit)
      begin
        pslverr <= 1'b0;
        prdata <= 32'h0000_0000;
      end
    end
  end

  // internal_wake_config; the stop-off bit also follows hardware, set over clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      internal_wake_config <= RST_INTERNAL;
    else if (soft_reset)
      internal_wake_config <= RST_INTERNAL;
    else
    begin
      if (restart)
        internal_wake_config <= internal_wake_config & KEEP_INTERNAL;
      else if (write_commit && reg_sel == 2'h0)
        internal_wake_config <= write_byte & RW_INTERNAL;
      if (stop_off_hw_set)
        internal_wake_config[BIT_STOP_OFF_HI] <= 1'b1;
      else if (stop_off_hw_clear)
        internal_wake_config[BIT_STOP_OFF_HI] <= 1'b0;
    end
  end

  // external_wake_config; fail-safe outranks restart and software
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      external_wake_config <= RST_EXTERNAL;
    else if (soft_reset)
      external_wake_config <= RST_EXTERNAL;
    else if (failsafe_entry)
      external_wake_config <= (external_wake_config & ~FAILSAFE_CLEAR) | FAILSAFE_SET;
    else if (restart)
      external_wake_config <= external_wake_config & KEEP_EXTERNAL;
    else if (write_commit && reg_sel == 2'h1)
      external_wake_config <= write_byte & RW_EXTERNAL;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      wake_input_termination <= RST_TERMINATION;
    else if (soft_reset)
      wake_input_termination <= RST_TERMINATION;
    else if (restart)
      wake_input_termination <= wake_input_termination & KEEP_TERMINATION;
    else if (write_commit && reg_sel == 2'h2)
      wake_input_termination <= write_byte & RW_TERMINATION;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      wake_input_filter <= RST_FILTER;
    else if (soft_reset)
      wake_input_filter <= RST_FILTER;
    else if (restart)
      wake_input_filter <= wake_input_filter & KEEP_FILTER;
    else if (write_commit && reg_sel == 2'h3)
      wake_input_filter <= write_byte & RW_FILTER;
  end

  // pins are asynchronous to pclk
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_meta <= 3'h0;
      pin_sync <= 3'h0;
    end
    else
    begin
      pin_meta <= {wake_pin_c, wake_pin_b, wake_pin_a};
      pin_sync <= pin_meta;
    end
  end

  assign measure_select = external_wake_config[BIT_MEASURE];
  assign global_interrupt = external_wake_config[BIT_INT_GLOBAL];
  // with measurement selected, inputs a and b lose their wake role
  assign wake_in_a_enable = external_wake_config[BIT_WAKE_A] && !measure_select;
  assign wake_in_b_enable = external_wake_config[BIT_WAKE_B] && !measure_select;
  assign wake_in_c_enable = external_wake_config[BIT_WAKE_C];
  assign input_armed = {wake_in_c_enable, wake_in_b_enable, wake_in_a_enable};

  // filter counts are dropped on soft reset and restart so a stale count cannot fire afterwards; the filtered level is kept
  generate
    for (genvar i = 0; i < WAKE_INPUTS; i++)
    begin : input_filter
      wake_input_filter u_filter (
        .pclk(pclk),
        .presetn(presetn),
        .clear(soft_reset || restart),
        .pin_level(pin_sync[i]),
        .filter_code(wake_input_filter[FIELD_W*i +: FIELD_W]),
        .on_end_a(timer_a_on_end),
        .on_end_b(timer_b_on_end),
        .wake_pulse(pin_filtered_wake[i]),
        .level(pin_level[i])
      );
    end
  endgenerate

  // a filtered edge on a disabled input is simply dropped
  assign next_wake_source = {
    timer_b_wake_tick && internal_wake_config[BIT_TIMER_B_WAKE],
    timer_a_wake_tick && internal_wake_config[BIT_TIMER_A_WAKE],
    pin_filtered_wake & input_armed
  };

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wake_source <= 5'h00;
      wake_event <= 1'b0;
    end
    else
    begin
      wake_source <= next_wake_source;
      wake_event <= |next_wake_source;
    end
  end

  // interrupt is a one-cycle request; the interrupt pin logic stretches it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      interrupt_request <= 1'b0;
    else
      interrupt_request <= (|next_wake_source) || (global_interrupt && status_event);
  end

  // bus control register lives elsewhere; it loads its wake-capable mode on this pulse
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      bus_wake_force <= 1'b0;
    else
      bus_wake_force <= failsafe_entry && !soft_reset;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cyclic_timer_a_wake_enable <= 1'b0;
      cyclic_timer_b_wake_enable <= 1'b0;
      watchdog_stop_off_hi <= 1'b0;
      measure_active <= 1'b0;
    end
    else
    begin
      cyclic_timer_a_wake_enable <= internal_wake_config[BIT_TIMER_A_WAKE];
      cyclic_timer_b_wake_enable <= internal_wake_config[BIT_TIMER_B_WAKE];
      watchdog_stop_off_hi <= internal_wake_config[BIT_STOP_OFF_HI];
      measure_active <= measure_select && normal_mode;
    end
  end

  // auto mode pulls toward the last filtered level to hold the pin quiet
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pull_up_enable <= 3'h0;
      pull_down_enable <= 3'h0;
    end
    else
    begin
      for (int i = 0; i < WAKE_INPUTS; i++)
      begin
        case (wake_input_termination[FIELD_W*i +: FIELD_W])
          TERM_PULL_DOWN:
          begin
            pull_up_enable[i] <= 1'b0;
            pull_down_enable[i] <= 1'b1;
          end
          TERM_PULL_UP:
          begin
            pull_up_enable[i] <= 1'b1;
            pull_down_enable[i] <= 1'b0;
          end
          TERM_AUTO:
          begin
            pull_up_enable[i] <= pin_level[i];
            pull_down_enable[i] <= !pin_level[i];
          end
          default:
          begin
            pull_up_enable[i] <= 1'b0;
            pull_down_enable[i] <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule

// file: dv/wake_cfg_monitor.sv
// port assertions for the wake source configuration block
`timescale 1ns/1ps
module wake_cfg_monitor
  import wake_cfg_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic failsafe_entry,
  input wire logic normal_mode,
  input wire logic timer_a_wake_tick,
  input wire logic timer_b_wake_tick,
  input wire logic cyclic_timer_a_wake_enable,
  input wire logic cyclic_timer_b_wake_enable,
  input wire logic measure_active,
  input wire logic [2:0] pull_up_enable,
  input wire logic [2:0] pull_down_enable,
  input wire logic wake_event,
  input wire logic [4:0] wake_source,
  input wire logic interrupt_request,
  input wire logic bus_wake_force
);
  logic mapped;
  assign mapped = paddr inside {8'h18, 8'h1C, 8'h20, 8'h24};
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("pready late");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held");
  a_upper_zero: assert property (pready |-> prdata[31:8] == 24'h000000)
    else $error("upper read bits set");
  a_map_err: assert property (pready |-> pslverr == !mapped)
    else $error("pslverr wrong for address");
  a_bus_force: assert property (failsafe_entry |=> bus_wake_force)
    else $error("no bus wake force");
  a_wake_named: assert property (wake_event |-> wake_source != 5'h00)
    else $error("wake without source");
  a_wake_int: assert property (wake_event |-> interrupt_request)
    else $error("wake without interrupt");
  a_timer_a: assert property (timer_a_wake_tick && cyclic_timer_a_wake_enable
    |=> ##[0:2] wake_source[3]) else $error("timer a wake lost");
  a_timer_b: assert property (timer_b_wake_tick && cyclic_timer_b_wake_enable
    |=> ##[0:2] wake_source[4]) else $error("timer b wake lost");
  a_meas_mode: assert property (measure_active |-> $past(normal_mode))
    else $error("measure outside normal mode");
  a_pull_excl: assert property ((pull_up_enable & pull_down_enable) == 3'h0)
    else $error("pull up and down together");
endmodule
bind wake_source_control_regs wake_cfg_monitor #(.ADDR_W(ADDR_W)) mon (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .failsafe_entry(failsafe_entry),
  .normal_mode(normal_mode), .timer_a_wake_tick(timer_a_wake_tick),
  .timer_b_wake_tick(timer_b_wake_tick), .measure_active(measure_active),
  .cyclic_timer_a_wake_enable(cyclic_timer_a_wake_enable),
  .cyclic_timer_b_wake_enable(cyclic_timer_b_wake_enable),
  .pull_up_enable(pull_up_enable), .pull_down_enable(pull_down_enable),
  .wake_event(wake_event), .wake_source(wake_source),
  .interrupt_request(interrupt_request), .bus_wake_force(bus_wake_force));

// file: dv/apb_host.sv
// apb master standing in for the host controller
`timescale 1ns/1ps
module apb_host
(
  input wire logic pclk,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb
);
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    pstrb = 4'h0;
  end
  // request held until pready is seen at a rising edge; idle cycle between transfers
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
    output logic [7:0] q, output logic e);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    pstrb <= 4'hF;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      tb.err_total++;
      tb.final_report();
    end
    q = prdata[7:0];
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

// file: dv/tb.sv
// self-checking bench for the wake source configuration block
`timescale 1ns/1ps
module tb
  import wake_cfg_pkg::*;
;
  logic pclk, presetn, normal_mode, psel, penable, pwrite, pready, pslverr;
  logic ta_en, tb_en, wd_off, meas, wev, irq, bwf;
  logic [9:0] ctl;
  logic [2:0] pins, pu, pd;
  logic [4:0] src;
  logic [7:0] paddr, q;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic e;
  int err_total, checked, n;
  localparam logic [7:0] A_INT = {IDX_INTERNAL, 2'b00};
  localparam logic [7:0] A_EXT = {IDX_EXTERNAL, 2'b00};
  localparam logic [7:0] A_TRM = {IDX_TERMINATION, 2'b00};
  localparam logic [7:0] A_FLT = {IDX_FILTER, 2'b00};
  apb_host h (.pclk(pclk), .pready(pready), .pslverr(pslverr), .prdata(prdata), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb));
  wake_source_control_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .soft_reset(ctl[0]),
    .restart(ctl[1]), .failsafe_entry(ctl[2]), .stop_off_hw_set(ctl[3]),
    .stop_off_hw_clear(ctl[4]), .normal_mode(normal_mode), .status_event(ctl[5]),
    .timer_a_wake_tick(ctl[6]), .timer_b_wake_tick(ctl[7]), .timer_a_on_end(ctl[8]),
    .timer_b_on_end(ctl[9]), .wake_pin_a(pins[0]), .wake_pin_b(pins[1]),
    .wake_pin_c(pins[2]), .cyclic_timer_a_wake_enable(ta_en),
    .cyclic_timer_b_wake_enable(tb_en), .watchdog_stop_off_hi(wd_off),
    .measure_active(meas), .pull_up_enable(pu), .pull_down_enable(pd), .wake_event(wev),
    .wake_source(src), .interrupt_request(irq), .bus_wake_force(bwf));
  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
    checked++;
    if (s !== x)
    begin
      err_total++;
      $display("FAIL %s expected %h seen %h", nm, x, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    h.xfer(1'b1, a, d, q, e);
  endtask
  task automatic rd(input string nm, input logic [7:0] a, input logic [7:0] x);
    h.xfer(1'b0, a, 8'h00, q, e);
    chk(nm, {24'h000000, q}, {24'h000000, x});
  endtask
  task automatic pulse(input int i);
    @(posedge pclk);
    ctl[i] <= 1'b1;
    @(posedge pclk);
    ctl[i] <= 1'b0;
    #1;
  endtask
  // bounded wait for a wake pulse; n equals lim when none came
  task automatic waitw(input int lim);
    n = 0;
    while (wev !== 1'b1 && n < lim)
    begin
      @(posedge pclk);
      #1;
      n++;
    end
  endtask
  task automatic t_regs();
    rd("int rst", A_INT, 8'h00);
    rd("ext rst", A_EXT, 8'h07);
    rd("trm rst", A_TRM, 8'h00);
    rd("flt rst", A_FLT, 8'h00);
    wr(A_INT, 8'hFF);
    wr(A_EXT, 8'hFF);
    wr(A_TRM, 8'hFF);
    wr(A_FLT, 8'hFF);
    rd("int rsv", A_INT, 8'hC4);
    rd("ext rsv", A_EXT, 8'hA7);
    rd("trm rsv", A_TRM, 8'h3F);
    rd("flt rsv", A_FLT, 8'h3F);
    chk("timer a en", ta_en, 1);
    chk("timer b en", tb_en, 1);
    chk("stop off", wd_off, 1);
    pulse(4);
    rd("hw clear", A_INT, 8'hC0);
    pulse(3);
    rd("hw set", A_INT, 8'hC4);
    h.xfer(1'b0, 8'h28, 8'h00, q, e);
    chk("unmapped err", e, 1);
    chk("unmapped data", q, 0);
    $display("done regs");
  endtask
  task automatic t_restart();
    pulse(1);
    rd("int rs", A_INT, 8'hC0);
    rd("ext rs", A_EXT, 8'hA7);
    rd("trm rs", A_TRM, 8'h3F);
    rd("flt rs", A_FLT, 8'h3F);
    wr(A_EXT, 8'h00);
    pulse(1);
    rd("ext kept", A_EXT, 8'h00);
    wr(A_EXT, 8'hA0);
    pulse(2);
    chk("bus force", bwf, 1);
    rd("ext fs", A_EXT, 8'hA7);
    pulse(0);
    rd("ext soft", A_EXT, 8'h07);
    rd("int soft", A_INT, 8'h00);
    $display("done restart");
  endtask
  task automatic t_term();
    wr(A_TRM, 8'h24);
    repeat (2) @(posedge pclk);
    #1;
    chk("pull up", pu, 3'h4);
    chk("pull down", pd, 3'h2);
    wr(A_TRM, 8'h3F);
    repeat (2) @(posedge pclk);
    #1;
    chk("auto down", pd, 3'h7);
    chk("auto up", pu, 3'h0);
    $display("done term");
  endtask
  task automatic t_wake();
    @(posedge pclk);
    pins[0] <= 1'b1;
    waitw(700);
    chk("short filter", n >= 640 && n <= 650, 1);
    chk("src a", src, 5'h01);
    chk("wake irq", irq, 1);
    wr(A_FLT, 8'h04);
    pins[1] <= 1'b1;
    waitw(2700);
    chk("long filter", n >= 2560 && n <= 2570, 1);
    chk("src b", src, 5'h02);
    wr(A_EXT, 8'h00);
    pins[2] <= 1'b1;
    waitw(800);
    chk("disabled c", n, 800);
    wr(A_EXT, 8'h23);
    normal_mode <= 1'b1;
    pins[0] <= 1'b0;
    pins[1] <= 1'b0;
    waitw(2700);
    chk("measure ignores", n, 2700);
    chk("measure on", meas, 1);
    @(posedge pclk);
    normal_mode <= 1'b0;
    wr(A_EXT, 8'h03);
    chk("measure off", meas, 0);
    pins[0] <= 1'b1;
    waitw(700);
    chk("src a again", src, 5'h01);
    $display("done wake");
  endtask
  task automatic t_irq_timer();
    wr(A_EXT, 8'h00);
    pulse(5);
    chk("status quiet", irq, 0);
    wr(A_EXT, 8'h80);
    pulse(5);
    chk("status irq", irq, 1);
    wr(A_INT, 8'h40);
    pulse(6);
    waitw(3);
    chk("tick a", src, 5'h08);
    pulse(7);
    waitw(3);
    chk("tick b off", n, 3);
    wr(A_INT, 8'h80);
    pulse(7);
    waitw(3);
    chk("tick b", src, 5'h10);
    pulse(6);
    waitw(3);
    chk("tick a off", n, 3);
    $display("done irq timer");
  endtask
  task automatic t_cyclic();
    wr(A_FLT, 8'h20);
    wr(A_EXT, 8'h04);
    pins[2] <= 1'b0;
    waitw(800);
    chk("cyclic waits", n, 800);
    pulse(8);
    waitw(4);
    chk("cyclic src", src, 5'h04);
    wr(A_FLT, 8'h30);
    pins[2] <= 1'b1;
    waitw(800);
    chk("cyclic b waits", n, 800);
    pulse(8);
    waitw(4);
    chk("wrong timer", n, 4);
    pulse(9);
    waitw(4);
    chk("cyclic b src", src, 5'h04);
    $display("done cyclic");
  endtask
  initial
  begin
    presetn = 1'b0;
    normal_mode = 1'b0;
    ctl = 10'h000;
    pins = 3'h0;
    err_total = 0;
    checked = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_restart();
    t_term();
    t_wake();
    t_irq_timer();
    t_cyclic();
    final_report();
  end
endmodule
